// ==== hw/rx_enable_params.svh ====
`ifndef RX_ENABLE_PARAMS_SVH
`define RX_ENABLE_PARAMS_SVH

// Register offsets on the serial port (address phase byte).
`define ADDR_IF_BUFFER_CONTROL 8'h50
`define ADDR_SUBCIRCUIT_ENABLES 8'h51
`define ADDR_RADIO_TRIM 8'h52
`define ADDR_RECEIVER_CHAIN_ENABLE 8'h60

// Field positions.
`define BIT_IF_OUTPUT_BUFFER_ON 0
`define BIT_VCO_ON 0
`define BIT_SYNTH_LOOP_ON 1
`define BIT_RF_AMPLIFIER_ON 2
`define BIT_MIXER_ON 3
`define BIT_IF_CHAIN_ON 4
`define BIT_GAIN_CONTROL_ON 5
`define BIT_MASTER_CHAIN_ENABLE 7
`define BIT_RF_CHAIN_FORCE_ON 7

// Reset values, identical in both strap modes.
`define RST_IF_BUFFER_CONTROL 8'h00
`define RST_SUBCIRCUIT_ENABLES 8'hff
`define RST_RADIO_TRIM 8'h1b
`define RST_RECEIVER_CHAIN_ENABLE 8'h33

// Strap dependent clock configuration defaults: sample clock on always,
// crystal clock on only in strap mode 1.
`define RST_SAMPLE_CLK_ON 1'b1

// Start-up periods in oscillator cycles.
`define CLKOUT_ENABLE_CYCLES 16'd1024
`define INTERNAL_RESET_CYCLES 16'd4096

// Serial transfer: one read/write flag plus seven address bits, then eight data bits.
`define SERIAL_BITS 5'd16

`endif

// ==== hw/rx_enable_pkg.sv ====
package rx_enable_pkg;

    // Power-up sequencer states.
    typedef enum logic [3:0] {
        PWR_STANDBY = 4'b0001,
        PWR_CLKOUT_WAIT = 4'b0010,
        PWR_INT_RESET = 4'b0100,
        PWR_RUN = 4'b1000
    } power_state_e;

    // Block enables presented to the analog section.
    typedef struct packed {
        logic osc_on;
        logic vco_on;
        logic synth_loop_on;
        logic rf_amplifier_on;
        logic mixer_on;
        logic if_chain_on;
        logic gain_control_on;
        logic if_output_buffer_on;
        logic sample_clk_buf_on;
        logic xtal_clk_buf_on;
    } block_enables_s;

    // One serial frame, decoded.
    typedef struct packed {
        logic write;
        logic [7:0] addr;
        logic [7:0] data;
    } serial_frame_s;

endpackage

// ==== hw/serial_frame_rx.sv ====
`timescale 1ns/100ps
`include "rx_enable_params.svh"

// Serial slave: address phase then data phase, sampled on the system clock.
module serial_frame_rx (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic [7:0] read_data,
    output logic sdo,
    output logic frame_valid,
    output rx_enable_pkg::serial_frame_s frame
);

    logic sclk_d_ff;
    logic [4:0] cnt_ff;
    logic [15:0] shift_ff;
    logic [7:0] out_ff;
    logic sdo_ff;
    logic valid_ff;
    rx_enable_pkg::serial_frame_s frame_ff;
    logic nxt_sclk_d, nxt_sdo, nxt_valid;
    logic [4:0] nxt_cnt;
    logic [15:0] nxt_shift;
    logic [7:0] nxt_out;
    rx_enable_pkg::serial_frame_s nxt_frame;

    // Shift on rising serial clock. The address is latched as soon as the address phase
    // ends, so the read mux answers for the frame in progress and not for the last one.
    always_comb begin
        nxt_sclk_d = sclk;
        nxt_cnt = cnt_ff;
        nxt_shift = shift_ff;
        nxt_out = out_ff;
        nxt_sdo = sdo_ff;
        nxt_valid = 1'b0;
        nxt_frame = frame_ff;
        if (cs_n) begin
            nxt_cnt = 5'd0;
            nxt_sdo = 1'b0;
        end else if (sclk && !sclk_d_ff) begin
            nxt_shift = {shift_ff[14:0], sdi};
            nxt_cnt = cnt_ff + 5'd1;
            if (cnt_ff == 5'd7) begin
                nxt_frame.addr = {1'b0, shift_ff[5:0], sdi};
            end
            if (cnt_ff == `SERIAL_BITS - 5'd1) begin
                nxt_frame.write = ~shift_ff[14];
                nxt_frame.addr = {1'b0, shift_ff[13:7]};
                nxt_frame.data = {shift_ff[6:0], sdi};
                nxt_valid = 1'b1;
                nxt_cnt = 5'd0;
            end
        end else if (!sclk && sclk_d_ff && cnt_ff >= 5'd8) begin
            // Data leaves on the falling edge, most significant bit first. The first fall
            // after the address phase takes the word straight from the read mux.
            if (cnt_ff == 5'd8) begin
                nxt_sdo = read_data[7];
                nxt_out = {read_data[6:0], 1'b0};
            end else begin
                nxt_sdo = out_ff[7];
                nxt_out = {out_ff[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d_ff <= 1'b0;
            cnt_ff <= 5'd0;
            shift_ff <= 16'h0000;
            out_ff <= 8'h00;
            sdo_ff <= 1'b0;
            valid_ff <= 1'b0;
            frame_ff <= '0;
        end else if (clk_en) begin
            sclk_d_ff <= nxt_sclk_d;
            cnt_ff <= nxt_cnt;
            shift_ff <= nxt_shift;
            out_ff <= nxt_out;
            sdo_ff <= nxt_sdo;
            valid_ff <= nxt_valid;
            frame_ff <= nxt_frame;
        end
    end

    assign sdo = sdo_ff;
    assign frame_valid = valid_ff;
    assign frame = frame_ff;

endmodule // serial_frame_rx

// ==== hw/rx_enable_regs.sv ====
`timescale 1ns/100ps
`include "rx_enable_params.svh"

module rx_enable_regs (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic chip_enable_pin,
    input wire logic rf_enable_pin,
    input wire logic strap_mode_pin,
    input wire logic factory_test_select_a,
    input wire logic factory_test_select_b,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic sample_clock_in,
    input wire logic sign_in,
    output logic sdo,
    output logic sample_clock_output,
    output logic sign_output,
    output logic xtal_clock_output,
    output logic [1:0] charge_pump_current_select,
    output logic [2:0] loop_filter_trim,
    output logic internal_reset_active,
    output rx_enable_pkg::block_enables_s enables
);

    // Sequencer, register bank and output state.
    rx_enable_pkg::power_state_e state_ff, nxt_state;
    logic [15:0] count_ff, nxt_count;
    logic chip_en_d_ff, nxt_chip_en_d;
    logic rf_low_at_rise_ff, nxt_rf_low_at_rise;
    logic [7:0] if_buffer_control_ff, nxt_if_buffer_control;
    logic [7:0] subcircuit_enables_ff, nxt_subcircuit_enables;
    logic [7:0] radio_trim_ff, nxt_radio_trim;
    logic [7:0] receiver_chain_enable_ff, nxt_receiver_chain_enable;
    logic strap_ff, nxt_strap;
    logic sample_clk_on_ff, nxt_sample_clk_on;
    logic xtal_clk_on_ff, nxt_xtal_clk_on;
    logic clkout_ready_ff, nxt_clkout_ready;
    rx_enable_pkg::block_enables_s en_ff, nxt_en;
    logic sample_out_ff, sign_out_ff, xtal_out_ff;
    logic nxt_sample_out, nxt_sign_out, nxt_xtal_out;
    logic frame_valid;
    rx_enable_pkg::serial_frame_s frame;
    logic [7:0] read_data;
    logic load_defaults;
    logic rf_chain_on;
    logic chip_en_rise;
    logic reg_write;
    logic chain_allowed;
    logic rf_request;

    // Address phase then data phase is handled by the serial receiver.
    // It also latches the address early so a read can answer within the same frame.
    serial_frame_rx u_serial (
        .clock(clock),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .sclk(sclk),
        .cs_n(cs_n),
        .sdi(sdi),
        .read_data(read_data),
        .sdo(sdo),
        .frame_valid(frame_valid),
        .frame(frame)
    );

    // The factory test selects only steer production test modes. In the application
    // they sit at fixed levels, so the bank gives them no function rather than guess
    // at behaviour that nobody can rely on.

    // A rise of the chip enable is taken against its registered copy, so a level that
    // is already high when reset lifts also counts as a wake-up.
    assign chip_en_rise = chip_enable_pin && !chip_en_d_ff;

    // Power-up sequencer: stand-by, clock-out wait, internal reset, run.
    // The counter runs on the system clock, which stands for the oscillator output.
    // One counter serves both periods; it is cleared between them so that each end
    // point is a single compare against its own constant.
    always_comb begin
        nxt_state = state_ff;
        nxt_count = count_ff;
        nxt_chip_en_d = chip_enable_pin;
        nxt_rf_low_at_rise = rf_low_at_rise_ff;
        nxt_clkout_ready = clkout_ready_ff;
        case (state_ff)
            rx_enable_pkg::PWR_STANDBY: begin
                nxt_count = 16'd0;
                nxt_clkout_ready = 1'b0;
                if (chip_en_rise) begin
                    nxt_state = rx_enable_pkg::PWR_CLKOUT_WAIT;
                    // The RF pin level at the rise decides whether defaults reload.
                    nxt_rf_low_at_rise = ~rf_enable_pin;
                end
            end
            rx_enable_pkg::PWR_CLKOUT_WAIT: begin
                // Clock outputs may start once this wait ends, well before the loop has settled.
                nxt_count = count_ff + 16'd1;
                if (count_ff == `CLKOUT_ENABLE_CYCLES - 16'd1) begin
                    nxt_clkout_ready = 1'b1;
                    nxt_count = 16'd0;
                    nxt_state = rx_enable_pkg::PWR_INT_RESET;
                end
            end
            rx_enable_pkg::PWR_INT_RESET: begin
                nxt_count = count_ff + 16'd1;
                if (count_ff == `INTERNAL_RESET_CYCLES - 16'd1) begin
                    nxt_state = rx_enable_pkg::PWR_RUN;
                end
            end
            rx_enable_pkg::PWR_RUN: begin
                // Run holds until the chip enable drops.
                nxt_count = 16'd0;
            end
            default: begin
                nxt_state = rx_enable_pkg::PWR_STANDBY;
            end
        endcase
        // Dropping the chip enable wins over every state, even in mid-count.
        if (!chip_enable_pin) begin
            nxt_state = rx_enable_pkg::PWR_STANDBY;
        end
    end

    // Sequencer state; the chip enable history for the rise detector lives here too.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= rx_enable_pkg::PWR_STANDBY;
            count_ff <= 16'd0;
            chip_en_d_ff <= 1'b0;
            rf_low_at_rise_ff <= 1'b1;
            clkout_ready_ff <= 1'b0;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            count_ff <= nxt_count;
            chip_en_d_ff <= nxt_chip_en_d;
            rf_low_at_rise_ff <= nxt_rf_low_at_rise;
            clkout_ready_ff <= nxt_clkout_ready;
        end
    end

    // The internal reset is simply the third sequencer state, so it lasts its full count
    // unless the chip enable drops first; no separate pulse stretcher is needed.
    assign internal_reset_active = (state_ff == rx_enable_pkg::PWR_INT_RESET);
    // Defaults load at the end of the internal reset only after a rise with RF pin low;
    // a rise with the RF pin high keeps what software wrote before stand-by.
    assign load_defaults = internal_reset_active &&
        (count_ff == `INTERNAL_RESET_CYCLES - 16'd1) && rf_low_at_rise_ff;

    // Serial writes are accepted only in run; during the internal reset the defaults
    // are still loading and a write would race them.
    assign reg_write = frame_valid && frame.write && state_ff == rx_enable_pkg::PWR_RUN;

    // Register bank with strap-chosen defaults; writes are ignored until run.
    // Reserved bits of the buffer and trim registers stay zero so reads show live fields.
    always_comb begin
        nxt_if_buffer_control = if_buffer_control_ff;
        nxt_subcircuit_enables = subcircuit_enables_ff;
        nxt_radio_trim = radio_trim_ff;
        nxt_receiver_chain_enable = receiver_chain_enable_ff;
        nxt_strap = strap_ff;
        nxt_sample_clk_on = sample_clk_on_ff;
        nxt_xtal_clk_on = xtal_clk_on_ff;
        if (load_defaults) begin
            nxt_if_buffer_control = `RST_IF_BUFFER_CONTROL;
            nxt_subcircuit_enables = `RST_SUBCIRCUIT_ENABLES;
            nxt_radio_trim = `RST_RADIO_TRIM;
            nxt_receiver_chain_enable = `RST_RECEIVER_CHAIN_ENABLE;
            nxt_strap = strap_mode_pin;
            nxt_sample_clk_on = `RST_SAMPLE_CLK_ON;
            nxt_xtal_clk_on = strap_mode_pin;
        end else if (reg_write) begin
            if (frame.addr == `ADDR_IF_BUFFER_CONTROL) begin
                nxt_if_buffer_control = {7'h00, frame.data[`BIT_IF_OUTPUT_BUFFER_ON]};
            end else if (frame.addr == `ADDR_SUBCIRCUIT_ENABLES) begin
                nxt_subcircuit_enables = frame.data;
            end else if (frame.addr == `ADDR_RADIO_TRIM) begin
                nxt_radio_trim = {3'h0, frame.data[4:0]};
            end else if (frame.addr == `ADDR_RECEIVER_CHAIN_ENABLE) begin
                nxt_receiver_chain_enable = frame.data;
            end
        end
    end

    // Register state; the reset values match the defaults of strap mode 0.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            if_buffer_control_ff <= `RST_IF_BUFFER_CONTROL;
            subcircuit_enables_ff <= `RST_SUBCIRCUIT_ENABLES;
            radio_trim_ff <= `RST_RADIO_TRIM;
            receiver_chain_enable_ff <= `RST_RECEIVER_CHAIN_ENABLE;
            strap_ff <= 1'b0;
            sample_clk_on_ff <= `RST_SAMPLE_CLK_ON;
            xtal_clk_on_ff <= 1'b0;
        end else if (clk_en) begin
            if_buffer_control_ff <= nxt_if_buffer_control;
            subcircuit_enables_ff <= nxt_subcircuit_enables;
            radio_trim_ff <= nxt_radio_trim;
            receiver_chain_enable_ff <= nxt_receiver_chain_enable;
            strap_ff <= nxt_strap;
            sample_clk_on_ff <= nxt_sample_clk_on;
            xtal_clk_on_ff <= nxt_xtal_clk_on;
        end
    end

    // Read mux returns stored fields; unmapped addresses read zero.
    // The address is that of the frame in progress, latched after its address phase.
    always_comb begin
        read_data = 8'h00;
        if (frame.addr == `ADDR_IF_BUFFER_CONTROL) begin
            read_data = if_buffer_control_ff;
        end else if (frame.addr == `ADDR_SUBCIRCUIT_ENABLES) begin
            read_data = subcircuit_enables_ff;
        end else if (frame.addr == `ADDR_RADIO_TRIM) begin
            read_data = radio_trim_ff;
        end else if (frame.addr == `ADDR_RECEIVER_CHAIN_ENABLE) begin
            read_data = receiver_chain_enable_ff;
        end
    end

    // The master bit gates the whole receive chain; outside run it is always off.
    assign chain_allowed = state_ff == rx_enable_pkg::PWR_RUN &&
        subcircuit_enables_ff[`BIT_MASTER_CHAIN_ENABLE];
    // Either the force bit or the RF pin asks for the chain.
    assign rf_request = receiver_chain_enable_ff[`BIT_RF_CHAIN_FORCE_ON] ||
        rf_enable_pin;
    // The RF chain runs only when the master bit, and force bit or RF pin, allow it.
    assign rf_chain_on = chain_allowed && rf_request;

    // Block enables are registered so the analog section never sees decode glitches.
    always_comb begin
        nxt_en.osc_on = state_ff != rx_enable_pkg::PWR_STANDBY;
        nxt_en.vco_on = rf_chain_on && subcircuit_enables_ff[`BIT_VCO_ON];
        nxt_en.synth_loop_on = rf_chain_on && subcircuit_enables_ff[`BIT_SYNTH_LOOP_ON];
        nxt_en.rf_amplifier_on = rf_chain_on && subcircuit_enables_ff[`BIT_RF_AMPLIFIER_ON];
        nxt_en.mixer_on = rf_chain_on && subcircuit_enables_ff[`BIT_MIXER_ON];
        nxt_en.if_chain_on = rf_chain_on && subcircuit_enables_ff[`BIT_IF_CHAIN_ON];
        nxt_en.gain_control_on = rf_chain_on && subcircuit_enables_ff[`BIT_GAIN_CONTROL_ON];
        nxt_en.if_output_buffer_on = rf_chain_on &&
            if_buffer_control_ff[`BIT_IF_OUTPUT_BUFFER_ON];
        // With the RF pin low only one clock buffer runs, picked by the strap.
        nxt_en.sample_clk_buf_on = clkout_ready_ff && sample_clk_on_ff &&
            (rf_enable_pin || !strap_ff);
        nxt_en.xtal_clk_buf_on = clkout_ready_ff && xtal_clk_on_ff &&
            (rf_enable_pin || strap_ff);
    end

    // Pass-through outputs are gated by the registered enables. A disabled output
    // drives low rather than float; the extra register costs one cycle of delay
    // but keeps enable changes from chopping a half-period into a runt pulse.
    always_comb begin
        nxt_sample_out = en_ff.sample_clk_buf_on & sample_clock_in;
        nxt_sign_out = en_ff.if_chain_on & sign_in;
        nxt_xtal_out = en_ff.xtal_clk_buf_on & en_ff.osc_on;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            en_ff <= '0;
            sample_out_ff <= 1'b0;
            sign_out_ff <= 1'b0;
            xtal_out_ff <= 1'b0;
        end else if (clk_en) begin
            en_ff <= nxt_en;
            sample_out_ff <= nxt_sample_out;
            sign_out_ff <= nxt_sign_out;
            xtal_out_ff <= nxt_xtal_out;
        end
    end

    // Outputs leave straight from flip-flops; the trim fields from the stored register.
    assign enables = en_ff;
    assign sample_clock_output = sample_out_ff;
    assign sign_output = sign_out_ff;
    assign xtal_clock_output = xtal_out_ff;
    assign charge_pump_current_select = radio_trim_ff[1:0];
    assign loop_filter_trim = radio_trim_ff[4:2];

endmodule // rx_enable_regs

// ==== tb/rx_enable_checker_properties.sv ====
`timescale 1ns/100ps
// Watches sequencing and output-buffer relations at the bank's pins.
module rx_enable_checker (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic chip_enable_pin,
    input wire logic cs_n,
    input wire logic sdo,
    input wire logic sample_clock_in,
    input wire logic sample_clock_output,
    input wire logic sign_in,
    input wire logic sign_output,
    input wire logic xtal_clock_output,
    input wire logic internal_reset_active,
    input wire rx_enable_pkg::block_enables_s enables
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // A wake-up after a real stand-by, so a pin glitch does not count.
    sequence power_up_s;
        !chip_enable_pin [*3] ##1 chip_enable_pin;
    endsequence

    standby_all_off_a: assert property (!chip_enable_pin [*4] |-> enables == '0)
        else $error("block enabled in stand-by");
    osc_start_a: assert property (power_up_s |-> ##[1:3] enables.osc_on)
        else $error("oscillator not started");
    clkout_wait_a: assert property (power_up_s |-> !enables.sample_clk_buf_on [*8])
        else $error("clock output enabled too early");
    reset_late_a: assert property (power_up_s |-> !internal_reset_active [*8])
        else $error("internal reset too early");
    reset_pulse_a: assert property ($rose(internal_reset_active)
        |-> internal_reset_active [*8])
        else $error("internal reset pulse too short");
    sdo_idle_low_a: assert property (cs_n [*4] |-> !sdo)
        else $error("serial output not low when idle");
    xtal_off_low_a: assert property (!enables.xtal_clk_buf_on [*2] |-> !xtal_clock_output)
        else $error("crystal output not low when off");
    sample_pass_a: assert property (enables.sample_clk_buf_on [*2]
        |-> sample_clock_output == $past(sample_clock_in))
        else $error("sample clock not passed through");
    sign_pass_a: assert property (enables.if_chain_on [*2]
        |-> sign_output == $past(sign_in))
        else $error("sign data not passed through");
    sign_off_low_a: assert property (!enables.if_chain_on [*2] |-> !sign_output)
        else $error("sign output not low when off");
endmodule // rx_enable_checker

bind rx_enable_regs rx_enable_checker chk (
    .clock(clock),
    .rst_n(rst_n),
    .chip_enable_pin(chip_enable_pin),
    .cs_n(cs_n),
    .sdo(sdo),
    .sample_clock_in(sample_clock_in),
    .sample_clock_output(sample_clock_output),
    .sign_in(sign_in),
    .sign_output(sign_output),
    .xtal_clock_output(xtal_clock_output),
    .internal_reset_active(internal_reset_active),
    .enables(enables)
);

// ==== tb/baseband_model.sv ====
`timescale 1ns/100ps
// Baseband serial master; the link clock stands low outside frames.
module baseband_model (
    input wire logic clock,
    input wire logic sdo,
    output logic sclk,
    output logic cs_n,
    output logic sdi
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end

    // One frame: flag and address phase, then data phase, MSB first. Each sclk level lasts
    // three clocks so the slave's edge detector never misses one.
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        logic [15:0] frame;
        frame = {rd, a, d};
        q = 8'h00;
        @(negedge clock);
        cs_n = 1'b0;
        repeat (3) @(negedge clock);
        for (int i = 15; i >= 0; i--) begin
            sdi = frame[i];
            repeat (3) @(negedge clock);
            if (i < 8) begin
                q[i] = sdo;
            end
            sclk = 1'b1;
            repeat (3) @(negedge clock);
            sclk = 1'b0;
        end
        repeat (3) @(negedge clock);
        cs_n = 1'b1;
        // Released line shows the inverse so a stale bit is never mistaken for data.
        sdi = ~sdi;
        repeat (3) @(negedge clock);
    endtask
endmodule // baseband_model

// ==== tb/tb_rx_enable_regs.sv ====
`timescale 1ns/100ps
module tb_rx_enable_regs;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] q;
        logic [9:0] e;
    } row_s;

    logic clock = 1'b0, rst_n = 1'b0, chip_enable_pin = 1'b0, rf_enable_pin = 1'b0;
    logic strap_mode_pin = 1'b0, sample_clock_in = 1'b0, sign_in = 1'b0;
    logic sclk, cs_n, sdi, sdo, sample_clock_output, sign_output, xtal_clock_output;
    logic internal_reset_active;
    logic [1:0] charge_pump_current_select;
    logic [2:0] loop_filter_trim;
    logic [7:0] q;
    logic [9:0] en;
    rx_enable_pkg::block_enables_s enables;
    int num_errors = 0, comparisons = 0;
    row_s rows [10] = '{
        '{8'h50, 8'hff, 8'h01, 10'h3fe},
        '{8'h51, 8'hfe, 8'hfe, 10'h2fe},
        '{8'h51, 8'hfd, 8'hfd, 10'h37e},
        '{8'h51, 8'hfb, 8'hfb, 10'h3be},
        '{8'h51, 8'hf7, 8'hf7, 10'h3de},
        '{8'h51, 8'hef, 8'hef, 10'h3ee},
        '{8'h51, 8'hdf, 8'hdf, 10'h3f6},
        '{8'h51, 8'h7f, 8'h7f, 10'h202},
        '{8'h51, 8'hff, 8'hff, 10'h3fe},
        '{8'h50, 8'h00, 8'h00, 10'h3fa}
    };

    assign en = enables;

    always #20 clock = ~clock;

    // Analog-side sources toggle so the pass-through buffers carry real traffic.
    always @(negedge clock) begin
        sample_clock_in <= ~sample_clock_in;
        sign_in <= sample_clock_in ^ sign_in;
    end

    baseband_model bb (.clock(clock), .sdo(sdo), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));

    rx_enable_regs dut (
        .clock(clock), .rst_n(rst_n), .clk_en(1'b1), .chip_enable_pin(chip_enable_pin),
        .rf_enable_pin(rf_enable_pin), .strap_mode_pin(strap_mode_pin),
        .factory_test_select_a(1'b0), .factory_test_select_b(1'b1), .sclk(sclk),
        .cs_n(cs_n), .sdi(sdi), .sample_clock_in(sample_clock_in), .sign_in(sign_in),
        .sdo(sdo), .sample_clock_output(sample_clock_output), .sign_output(sign_output),
        .xtal_clock_output(xtal_clock_output),
        .charge_pump_current_select(charge_pump_current_select),
        .loop_filter_trim(loop_filter_trim),
        .internal_reset_active(internal_reset_active), .enables(enables)
    );

    task automatic summarize();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Register access, then time for the write to reach the registered enables.
    task automatic rw(input logic rd, input logic [7:0] a, input logic [7:0] d);
        bb.xfer(rd, a[6:0], d, q);
        repeat (4) @(negedge clock);
    endtask

    // Raise chip enable and time both start-up periods; a stuck sequencer ends the run.
    task automatic power_up();
        int n;
        n = 0;
        chip_enable_pin = 1'b1;
        while (internal_reset_active !== 1'b1 && n < 2000) begin
            @(negedge clock);
            n++;
        end
        check("clkout_period", 16'(n >= 1023 && n <= 1027), 16'h1);
        n = 0;
        while (internal_reset_active !== 1'b0 && n < 5000) begin
            @(negedge clock);
            n++;
        end
        check("reset_period", 16'(n >= 4094 && n <= 4098), 16'h1);
        if (num_errors > 0) begin
            summarize();
        end
        repeat (4) @(negedge clock);
    endtask

    initial begin
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        repeat (2) @(negedge clock);
        check("standby", 16'(en), 16'h0);
        power_up();
        check("rf_low_strap0", 16'(en), 16'h202);
        check("xtal_off_strap0", 16'(xtal_clock_output), 16'h0);
        // Defaults as read back over the serial port.
        rw(1'b1, 8'h50, 8'h00);
        check("reg50", 16'(q), 16'h00);
        rw(1'b1, 8'h51, 8'h00);
        check("reg51", 16'(q), 16'hff);
        rw(1'b1, 8'h52, 8'h00);
        check("reg52", 16'(q), 16'h1b);
        rw(1'b1, 8'h60, 8'h00);
        check("reg60", 16'(q), 16'h33);
        rf_enable_pin = 1'b1;
        repeat (4) @(negedge clock);
        check("rf_high", 16'(en), 16'h3fa);
        // Ordinary write and read-back cases.
        foreach (rows[i]) begin
            rw(1'b0, rows[i].a, rows[i].d);
            check("row_enables", 16'(en), 16'(rows[i].e));
            rw(1'b1, rows[i].a, 8'h00);
            check("row_read", 16'(q), 16'(rows[i].q));
        end
        // Force bit overrides a low RF pin, then hands control back to it.
        rf_enable_pin = 1'b0;
        rw(1'b0, 8'h60, 8'hb3);
        check("forced_rf", 16'(en[6:5]), 16'h3);
        rw(1'b0, 8'h60, 8'h33);
        check("pin_rf", 16'(en[6:5]), 16'h0);
        for (int c = 0; c < 4; c++) begin
            rw(1'b0, 8'h52, 8'h14 | 8'(c));
            check("cp_select", 16'(charge_pump_current_select), 16'(c));
            check("lf_trim", 16'(loop_filter_trim), 16'h5);
        end
        // Stand-by, then a wake-up with the RF pin low restores defaults.
        chip_enable_pin = 1'b0;
        repeat (6) @(negedge clock);
        check("standby_en", 16'(en), 16'h0);
        check("xtal_low", 16'(xtal_clock_output), 16'h0);
        check("sample_low", 16'(sample_clock_output), 16'h0);
        check("sign_low", 16'(sign_output), 16'h0);
        power_up();
        rw(1'b1, 8'h52, 8'h00);
        check("reg52_reload", 16'(q), 16'h1b);
        chip_enable_pin = 1'b0;
        strap_mode_pin = 1'b1;
        repeat (6) @(negedge clock);
        power_up();
        check("rf_low_strap1", 16'(en & 10'h3fd), 16'h201);
        check("xtal_on_strap1", 16'(xtal_clock_output), 16'h1);
        check("sample_off_strap1", 16'(sample_clock_output), 16'h0);
        summarize();
    end
endmodule // tb_rx_enable_regs
